/* File: logic/sfpw_core.sv */
`timescale 1ns/100ps
`default_nettype none
// Operation
// RQ1 - wrap-set: opcode, 24 ignored bits, one wrap byte, then chip select high.
// RQ2 - wrap-disable low enables wrap; length codes give 8, 16, 32, 64 bytes.
// RQ3 - wrapped reads restart at section start within the page until deselect.
// RQ4 - stored wrap setting governs every later quad read until rewritten.
// RQ5 - host stops wrapping by writing wrap-disable high again.
// RQ6 - four-lane wrapped read opcode uses stored length; parameter command changes it.
// RQ7 - program and erase need write-enable latch set beforehand.
// RQ8 - single-lane program: opcode, three address bytes, data bytes on lane 0.
// RQ9 - program data past page end wraps to offset zero of same page.
// RQ10 - over 256 data bytes: only last 256 are kept and programmed. Byte count stops at 511: data bytes 509 on share one slot.
// RQ11 - fewer than 256 bytes: untouched page bytes stay unchanged.
// RQ12 - program runs only if deselect falls exactly on a byte boundary.
// RQ13 - deselect starts timed program; busy high, latch cleared before end.
// RQ14 - status reads answered during self-timed cycles.
// RQ15 - program into protected page is not carried out.
// RQ16 - four-lane program needs quad enable; address and data on four lanes.
// RQ17 - sector erase: opcode plus three address bytes; any address selects sector.
// RQ18 - erase runs only if deselect follows third address byte exactly.
// RQ19 - valid erase starts timed cycle; busy high, latch cleared before end.
// RQ20 - 32KB block erase framed alike; protected block left untouched.
// RQ21 - erase of protected sector is ignored.
// RQ22 - host holds chip select low throughout each command.
// RQ23 - while busy, program, erase and wrap commands are ignored.
// RQ24 - four-lane program allowed only with quad enable bit set.
module sfpw_core #(
	parameter int unsigned PROG_CYCLES  = sfpw_pkg::PROG_TIME_US
	                                      * sfpw_pkg::CLK_MHZ,
	parameter int unsigned ERASE_CYCLES = sfpw_pkg::ERASE_TIME_US
	                                      * sfpw_pkg::CLK_MHZ
) (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        cs_n,
	input  wire logic        sclk,
	input  wire logic [3:0]  data_lane_in,
	output logic      [3:0]  data_lane_out,
	output logic      [3:0]  data_lane_oe_n,
	input  wire logic        four_lane_command_mode,
	input  wire logic        quad_enable_bit,
	input  wire logic        protect_active,
	input  wire logic [23:0] protect_lo_addr,
	input  wire logic [23:0] protect_hi_addr,
	input  wire logic        rd_load,
	input  wire logic [23:0] rd_start_addr,
	input  wire logic        rd_step,
	input  wire logic        rd_quad_std,
	input  wire logic        rd_wrap_cmd,
	output logic      [23:0] rd_addr_ff,
	output logic             busy_flag,
	output logic             write_enable_latch,
	output logic             wrap_disable_bit,
	output logic      [1:0]  wrap_length_bits,
	output logic             mem_wr_ff,
	output logic      [23:0] mem_addr_ff,
	output logic      [7:0]  mem_data_ff,
	output logic             erase_req_ff,
	output logic      [23:0] erase_addr_ff,
	output logic             erase_blk32_ff
);
	import sfpw_pkg::*;

	function automatic logic [23:0] read_next(input logic [23:0] a,
	                                          input logic wrap,
	                                          input logic [1:0] len);
		logic [7:0] m;
		logic [7:0] inc;
		m = 8'(({5'h0, 3'h7} << len) | 8'(len != 2'h0 ? 8'h07 : 8'h00));
		m = 8'((8'h08 << len) - 8'h01);
		inc = a[7:0] + 8'h01;
		if (wrap)
			read_next = {a[23:8], (a[7:0] & ~m) | (inc & m)};
		else
			read_next = a + 24'h000001;
	endfunction

	function automatic logic overlap(input logic [23:0] base,
	                                 input logic [23:0] last,
	                                 input logic act,
	                                 input logic [23:0] lo,
	                                 input logic [23:0] hi);
		overlap = act && !(last < lo || base > hi);
	endfunction

	sfpw_state_t state_ff;
	logic        sclk_q_ff;
	logic        cs_q_ff;
	logic [2:0]  cnt_ff;
	logic [2:0]  ocnt_ff;
	logic [7:0]  sh_ff;
	logic [7:0]  opc_ff;
	logic [8:0]  byte_cnt_ff;
	logic [23:0] addr_ff;
	logic [7:0]  wrap_byte_ff;
	logic [7:0]  page_buf [PAGE_SIZE];
	logic [PAGE_SIZE-1:0] vld_ff;
	logic [31:0] timer_ff;
	logic        prog_run_ff;
	logic [8:0]  ptr_ff;

	logic        rise_e;
	logic        fall_e;
	logic        cs_rise;
	logic        wide;
	logic [3:0]  sum;
	logic        byte_done;
	logic [7:0]  nxt_sh;
	logic [7:0]  slot;
	logic        bnd;
	logic        is_prog;
	logic        is_erase;
	logic [23:0] er_base;
	logic [23:0] er_last;
	logic        go_prog;
	logic        go_erase;
	logic        go_write_enable_command;
	logic        go_wrdi;
	logic        go_wrap;
	logic        go_param;
	logic [7:0]  stat_byte;

	assign rise_e  = !cs_n && sclk && !sclk_q_ff;
	assign fall_e  = !cs_n && !sclk && sclk_q_ff;
	assign cs_rise = cs_n && !cs_q_ff;
	assign wide    = four_lane_command_mode
	                 || (opc_ff == OP_PROG_QUAD && state_ff != ST_OPC); // [RQ16]
	assign sum     = {1'b0, cnt_ff} + (wide ? 4'h4 : 4'h1);
	assign byte_done = rise_e && sum[3];
	assign nxt_sh  = wide ? {sh_ff[3:0], data_lane_in}
	                      : {sh_ff[6:0], data_lane_in[0]};
	assign slot    = addr_ff[7:0] + byte_cnt_ff[7:0] - 8'(ADDR_BYTES); // [RQ9]
	assign bnd     = cnt_ff == 3'h0; // [RQ12] [RQ18]
	assign is_prog = opc_ff == OP_PROG || opc_ff == OP_PROG_QUAD;
	assign is_erase = opc_ff == OP_SECT_ERASE || opc_ff == OP_BLK32_ERASE;
	assign er_base = opc_ff == OP_BLK32_ERASE
	                 ? {addr_ff[23:BLK32_BITS], BLK32_BITS'(0)}
	                 : {addr_ff[23:SECT_BITS], SECT_BITS'(0)}; // [RQ17] [RQ20]
	assign er_last = opc_ff == OP_BLK32_ERASE
	                 ? {addr_ff[23:BLK32_BITS], {BLK32_BITS{1'b1}}}
	                 : {addr_ff[23:SECT_BITS], {SECT_BITS{1'b1}}};
	assign go_prog = cs_rise && state_ff == ST_DATA && bnd && is_prog
	                 && byte_cnt_ff > 9'(ADDR_BYTES) && write_enable_latch
	                 && !overlap({addr_ff[23:PAGE_BITS], PAGE_BITS'(0)},
	                             {addr_ff[23:PAGE_BITS], {PAGE_BITS{1'b1}}},
	                             protect_active, protect_lo_addr,
	                             protect_hi_addr); // [RQ7] [RQ12] [RQ15]
	assign go_erase = cs_rise && state_ff == ST_DATA && bnd && is_erase
	                  && byte_cnt_ff == 9'(ADDR_BYTES) && write_enable_latch
	                  && !overlap(er_base, er_last, protect_active,
	                              protect_lo_addr, protect_hi_addr); // [RQ7] [RQ18] [RQ21] [RQ20]
	assign go_write_enable_command = cs_rise && state_ff == ST_DATA && bnd
	                 && opc_ff == OP_WRITE_ENABLE_COMMAND && byte_cnt_ff == 9'h0;
	assign go_wrdi = cs_rise && state_ff == ST_DATA && bnd
	                 && opc_ff == OP_WRDI && byte_cnt_ff == 9'h0;
	assign go_wrap = cs_rise && state_ff == ST_DATA && bnd
	                 && opc_ff == OP_WRAP_SET
	                 && byte_cnt_ff == 9'(ADDR_BYTES + 1); // [RQ1]
	assign go_param = cs_rise && state_ff == ST_DATA && bnd
	                  && opc_ff == OP_SET_PARAM && byte_cnt_ff == 9'h1; // [RQ6]

	always_comb begin
		stat_byte = 8'h00;
		if (opc_ff == OP_STAT_HI) begin
			stat_byte[STAT_QE_POS] = quad_enable_bit;
		end else begin
			stat_byte[STAT_BUSY_POS] = busy_flag;
			stat_byte[STAT_WEL_POS]  = write_enable_latch;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			sclk_q_ff <= 1'b0;
			cs_q_ff   <= 1'b1;
		end else begin
			sclk_q_ff <= sclk;
			cs_q_ff   <= cs_n;
		end
	end

	// command framing
	always_ff @(posedge clk) begin
		if (rst || cs_n) begin
			state_ff    <= ST_OPC;
			cnt_ff      <= 3'h0;
			sh_ff       <= 8'h00;
			byte_cnt_ff <= 9'h000;
		end else if (rise_e) begin
			sh_ff  <= nxt_sh;
			cnt_ff <= sum[2:0];
			if (byte_done) begin
				if (state_ff != ST_OPC && byte_cnt_ff != 9'h1ff)
					byte_cnt_ff <= byte_cnt_ff + 9'h001;
				unique case (state_ff)
					ST_OPC: begin
						if (nxt_sh == OP_STAT_LO || nxt_sh == OP_STAT_HI)
							state_ff <= ST_STAT; // [RQ14]
						else if (busy_flag)
							state_ff <= ST_IGN; // [RQ23]
						else if (nxt_sh == OP_PROG || nxt_sh == OP_SECT_ERASE
						         || nxt_sh == OP_BLK32_ERASE
						         || nxt_sh == OP_WRAP_SET)
							state_ff <= ST_ADDR; // [RQ8] [RQ17]
						else if (nxt_sh == OP_PROG_QUAD)
							state_ff <= quad_enable_bit ? ST_ADDR : ST_IGN; // [RQ24] [RQ16]
						else if (nxt_sh == OP_WRITE_ENABLE_COMMAND || nxt_sh == OP_WRDI
						         || (nxt_sh == OP_SET_PARAM
						             && four_lane_command_mode))
							state_ff <= ST_DATA;
						else
							state_ff <= ST_IGN;
					end
					ST_ADDR: begin
						if (byte_cnt_ff == 9'(ADDR_BYTES - 1))
							state_ff <= ST_DATA;
					end
					ST_DATA, ST_STAT, ST_IGN: begin
					end
					default: state_ff <= ST_IGN;
				endcase
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			opc_ff       <= 8'h00;
			addr_ff      <= 24'h000000;
			wrap_byte_ff <= 8'h00;
		end else if (byte_done) begin
			if (state_ff == ST_OPC)
				opc_ff <= nxt_sh;
			if (state_ff == ST_ADDR)
				addr_ff <= {addr_ff[15:0], nxt_sh};
			if (state_ff == ST_DATA)
				wrap_byte_ff <= nxt_sh; // [RQ1]
		end
	end

	// page buffer; later bytes overwrite earlier ones at the same slot
	always_ff @(posedge clk) begin
		if (byte_done && state_ff == ST_DATA && is_prog)
			page_buf[slot] <= nxt_sh; // [RQ9] [RQ10]
	end

	always_ff @(posedge clk) begin
		if (rst)
			vld_ff <= '0;
		else if (byte_done && state_ff == ST_OPC && !busy_flag)
			vld_ff <= '0; // [RQ11]
		else if (byte_done && state_ff == ST_DATA && is_prog)
			vld_ff[slot] <= 1'b1; // [RQ11]
	end

	// wrap setting and read address sequencing
	always_ff @(posedge clk) begin
		if (rst) begin
			wrap_disable_bit <= WRAP_DIS_RST;
			wrap_length_bits <= WRAP_LEN_RST;
		end else if (go_wrap) begin
			wrap_disable_bit <= wrap_byte_ff[WRAP_DIS_POS]; // [RQ2] [RQ5]
			wrap_length_bits <= wrap_byte_ff[WRAP_LEN_LSB +: 2]; // [RQ2]
		end else if (go_param) begin
			wrap_length_bits <= wrap_byte_ff[PARAM_LEN_LSB +: 2]; // [RQ6]
		end
	end

	always_ff @(posedge clk) begin
		if (rst)
			rd_addr_ff <= 24'h000000;
		else if (rd_load)
			rd_addr_ff <= rd_start_addr;
		else if (rd_step)
			rd_addr_ff <= read_next(rd_addr_ff,
			                        rd_wrap_cmd
			                        || (rd_quad_std && !wrap_disable_bit),
			                        wrap_length_bits); // [RQ3] [RQ4] [RQ6]
	end

	// write enable latch
	always_ff @(posedge clk) begin
		if (rst)
			write_enable_latch <= 1'b0;
		else if (go_write_enable_command)
			write_enable_latch <= 1'b1;
		else if (go_wrdi
		         || (busy_flag && timer_ff == 32'(WEL_CLR_LEAD)))
			write_enable_latch <= 1'b0; // [RQ13] [RQ19]
	end

	// self-timed program and erase cycle
	always_ff @(posedge clk) begin
		if (rst) begin
			busy_flag   <= 1'b0;
			timer_ff    <= 32'h0;
			prog_run_ff <= 1'b0;
		end else if (go_prog || go_erase) begin
			busy_flag   <= 1'b1; // [RQ13] [RQ19]
			timer_ff    <= go_prog ? 32'(PROG_CYCLES - 1)
			                       : 32'(ERASE_CYCLES - 1);
			prog_run_ff <= go_prog;
		end else if (busy_flag) begin
			timer_ff <= timer_ff - 32'h1;
			if (timer_ff == 32'h0) begin
				busy_flag   <= 1'b0;
				prog_run_ff <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			ptr_ff      <= 9'h000;
			mem_wr_ff   <= 1'b0;
			mem_addr_ff <= 24'h000000;
			mem_data_ff <= 8'h00;
		end else if (go_prog) begin
			ptr_ff    <= 9'h000;
			mem_wr_ff <= 1'b0;
		end else if (prog_run_ff && !ptr_ff[8]) begin
			ptr_ff      <= ptr_ff + 9'h001;
			mem_wr_ff   <= vld_ff[ptr_ff[7:0]]; // [RQ11]
			mem_addr_ff <= {addr_ff[23:PAGE_BITS], ptr_ff[7:0]};
			mem_data_ff <= page_buf[ptr_ff[7:0]];
		end else begin
			mem_wr_ff <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			erase_req_ff   <= 1'b0;
			erase_addr_ff  <= 24'h000000;
			erase_blk32_ff <= 1'b0;
		end else begin
			erase_req_ff <= go_erase;
			if (go_erase) begin
				erase_addr_ff  <= er_base; // [RQ17] [RQ20]
				erase_blk32_ff <= opc_ff == OP_BLK32_ERASE;
			end
		end
	end

	// status read-out on falling serial clock
	always_ff @(posedge clk) begin
		if (rst || cs_n) begin
			data_lane_out  <= 4'h0;
			data_lane_oe_n <= 4'hf;
			ocnt_ff        <= 3'h0;
		end else if (fall_e && state_ff == ST_STAT) begin
			if (four_lane_command_mode) begin
				data_lane_out  <= ocnt_ff[2] ? stat_byte[3:0]
				                             : stat_byte[7:4]; // [RQ14]
				data_lane_oe_n <= 4'h0;
				ocnt_ff        <= ocnt_ff + 3'h4;
			end else begin
				data_lane_out  <= {2'b00, stat_byte[3'h7 - ocnt_ff], 1'b0}; // [RQ14]
				data_lane_oe_n <= 4'hd;
				ocnt_ff        <= ocnt_ff + 3'h1;
			end
		end
	end
endmodule // sfpw_core
`default_nettype wire

/* File: logic/sfpw_pkg.sv */
`default_nettype none
package sfpw_pkg;
	localparam logic [7:0] OP_WRITE_ENABLE_COMMAND        = 8'h06;
	localparam logic [7:0] OP_WRDI        = 8'h04;
	localparam logic [7:0] OP_STAT_LO     = 8'h05;
	localparam logic [7:0] OP_STAT_HI     = 8'h35;
	localparam logic [7:0] OP_WRAP_SET    = 8'h77;
	localparam logic [7:0] OP_PROG        = 8'h02;
	localparam logic [7:0] OP_PROG_QUAD   = 8'h32;
	localparam logic [7:0] OP_SECT_ERASE  = 8'h20;
	localparam logic [7:0] OP_BLK32_ERASE = 8'h52;
	localparam logic [7:0] OP_SET_PARAM   = 8'hc0;
	localparam logic [7:0] OP_WRAP_READ4  = 8'h0c;
	// wrap byte layout
	localparam int         WRAP_DIS_POS   = 4;
	localparam int         WRAP_LEN_LSB   = 5;
	localparam int         PARAM_LEN_LSB  = 0;
	localparam logic       WRAP_DIS_RST   = 1'b1;
	localparam logic [1:0] WRAP_LEN_RST   = 2'h3;
	// status bit positions within each status byte
	localparam int         STAT_BUSY_POS  = 0;
	localparam int         STAT_WEL_POS   = 1;
	localparam int         STAT_QE_POS    = 1;
	// address field sizes in bits; address length and page size in bytes
	localparam int         PAGE_BITS      = 8;
	localparam int         SECT_BITS      = 12;
	localparam int         BLK32_BITS     = 15;
	localparam int         ADDR_BYTES     = 3;
	localparam int         PAGE_SIZE      = 256;
	// self-timed cycle times
	localparam int         CLK_MHZ        = 200;
	localparam int         PROG_TIME_US   = 600;
	localparam int         ERASE_TIME_US  = 50000;
	localparam int         WEL_CLR_LEAD   = 1;
	typedef enum logic [2:0] {
		ST_OPC  = 3'b000,
		ST_ADDR = 3'b001,
		ST_DATA = 3'b010,
		ST_STAT = 3'b011,
		ST_IGN  = 3'b100
	} sfpw_state_t;
endpackage
`default_nettype wire

/* File: testbench/sfpw_core_sva.sv */
`timescale 1ns/100ps
`default_nettype none
module sfpw_chk #(
	parameter int unsigned PROG_CYCLES  = 300,
	parameter int unsigned ERASE_CYCLES = 300
) (
	input wire logic        clk,
	input wire logic        rst,
	input wire logic        cs_n,
	input wire logic        rd_load,
	input wire logic        rd_step,
	input wire logic        rd_quad_std,
	input wire logic [23:0] rd_addr_ff,
	input wire logic        busy_flag,
	input wire logic        write_enable_latch,
	input wire logic        wrap_disable_bit,
	input wire logic [1:0]  wrap_length_bits,
	input wire logic        mem_wr_ff,
	input wire logic [23:0] mem_addr_ff,
	input wire logic        erase_req_ff,
	input wire logic [23:0] erase_addr_ff,
	input wire logic        erase_blk32_ff
);
	logic [31:0] cnt_ff;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// cycles spent busy so far
	always_ff @(posedge clk) begin
		if (rst || !busy_flag)
			cnt_ff <= 32'h0;
		else
			cnt_ff <= cnt_ff + 32'h1;
	end
	busy_start_a: assert property (
		$rose(busy_flag) |-> $past(cs_n) && $past(write_enable_latch))
		else $error("busy without enabled closed frame");
	wel_first_a: assert property (
		$fell(busy_flag) |-> !$past(write_enable_latch))
		else $error("latch still set at end of cycle");
	busy_len_a: assert property (
		$fell(busy_flag) |-> cnt_ff == PROG_CYCLES || cnt_ff == ERASE_CYCLES)
		else $error("self-timed cycle length wrong");
	erase_pulse_a: assert property (
		erase_req_ff |-> busy_flag && $past(cs_n) ##1 !erase_req_ff)
		else $error("erase request badly timed");
	erase_align_a: assert property (
		erase_req_ff |-> (erase_blk32_ff ? erase_addr_ff[14:0] == 15'h0
		: erase_addr_ff[11:0] == 12'h0)) else $error("erase base unaligned");
	wr_busy_a: assert property (mem_wr_ff |-> busy_flag)
		else $error("array write outside cycle");
	wr_page_a: assert property (
		mem_wr_ff && $past(mem_wr_ff) |-> mem_addr_ff[23:8] ==
		$past(mem_addr_ff[23:8]) && mem_addr_ff[7:0] > $past(mem_addr_ff[7:0]))
		else $error("program left page or order");
	wrap_hold_a: assert property (
		$changed({wrap_disable_bit, wrap_length_bits}) |-> $past(cs_n)
		&& !$past(busy_flag)) else $error("wrap setting changed wrongly");
	wrap_page_a: assert property (
		rd_step && !rd_load && rd_quad_std && !wrap_disable_bit |=>
		rd_addr_ff[23:8] == $past(rd_addr_ff[23:8]))
		else $error("wrapped read left page");
	cover property ($rose(busy_flag));
	cover property (erase_req_ff && erase_blk32_ff);
	cover property ($fell(wrap_disable_bit));
endmodule // sfpw_chk
bind sfpw_core sfpw_chk #(.PROG_CYCLES(PROG_CYCLES),
	.ERASE_CYCLES(ERASE_CYCLES)) u_chk (.clk, .rst, .cs_n, .rd_load,
	.rd_step, .rd_quad_std, .rd_addr_ff, .busy_flag, .write_enable_latch,
	.wrap_disable_bit, .wrap_length_bits, .mem_wr_ff, .mem_addr_ff,
	.erase_req_ff, .erase_addr_ff, .erase_blk32_ff);
`default_nettype wire

/* File: testbench/sfpw_host.sv */
`timescale 1ns/100ps
`default_nettype none
module sfpw_host (
	input  wire logic       clk,
	output logic            cs_n,
	output logic            sclk,
	output logic      [3:0] data_lane_in,
	input  wire logic [3:0] data_lane_out
);
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		data_lane_in = 4'h0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	// data changes with sclk low, held across the rise
	task automatic lane(input logic [3:0] v);
		sclk <= 1'b0;
		data_lane_in <= v;
		tick(2);
		sclk <= 1'b1;
		tick(2);
	endtask
	task automatic start();
		cs_n <= 1'b0;
		tick(2);
	endtask
	task automatic put(input logic [7:0] b, input int n, input bit quad);
		if (quad) begin
			lane(b[7:4]);
			lane(b[3:0]);
		end else begin
			for (int i = 7; i > 7 - n; i--)
				lane({~data_lane_in[3:1], b[i]});
		end
	endtask
	// released lanes show the inverse of the last value
	task automatic stop();
		sclk <= 1'b0;
		tick(2);
		cs_n <= 1'b1;
		data_lane_in <= ~data_lane_in;
		tick(3);
	endtask
	task automatic rdstat(output logic [7:0] s);
		for (int i = 7; i >= 0; i--) begin
			sclk <= 1'b0;
			tick(3);
			s[i] = data_lane_out[1];
			sclk <= 1'b1;
			tick(2);
		end
	endtask
endmodule // sfpw_host
`default_nettype wire

/* File: testbench/sfpw_core_test.sv */
`timescale 1ns/100ps
`default_nettype none
module sfpw_core_test;
	import sfpw_pkg::*;
	localparam int unsigned CYC = 300;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        cs_n, sclk, busy_flag, write_enable_latch, wrap_disable_bit;
	logic [3:0]  data_lane_in, data_lane_out;
	logic        quad_enable_bit = 1'b0;
	logic        four_lane_command_mode = 1'b0;
	logic [3:0]  oe_n;
	logic        protect_active = 1'b0;
	logic [23:0] protect_lo_addr = 24'h030000;
	logic [23:0] protect_hi_addr = 24'h03ffff;
	logic        rd_load = 1'b0, rd_step = 1'b0;
	logic        rd_quad_std = 1'b0, rd_wrap_cmd = 1'b0;
	logic [23:0] rd_start_addr = 24'h0;
	logic [23:0] rd_addr_ff, mem_addr_ff, erase_addr_ff, ea;
	logic [1:0]  wrap_length_bits;
	logic        mem_wr_ff, erase_req_ff, erase_blk32_ff, eb;
	logic [7:0]  mem_data_ff, s;
	logic [7:0]  img [256];
	logic [15:0] pg;
	int          mismatches = 0, n_compared = 0, nwr = 0, ner = 0;
	logic [7:0]  eop [4] = '{8'h20, 8'h52, 8'h20, 8'h52};
	logic [23:0] ead [4] = '{24'h012345, 24'h01abcd, 24'h030100, 24'h012345};

	always #2.5 clk = ~clk;
	sfpw_core #(.PROG_CYCLES(CYC), .ERASE_CYCLES(CYC)) u_dut (
		.clk, .rst, .cs_n, .sclk, .data_lane_in, .data_lane_out,
		.data_lane_oe_n(oe_n), .four_lane_command_mode, .quad_enable_bit,
		.protect_active, .protect_lo_addr, .protect_hi_addr, .rd_load,
		.rd_start_addr, .rd_step, .rd_quad_std, .rd_wrap_cmd, .rd_addr_ff,
		.busy_flag, .write_enable_latch, .wrap_disable_bit,
		.wrap_length_bits, .mem_wr_ff, .mem_addr_ff, .mem_data_ff,
		.erase_req_ff, .erase_addr_ff, .erase_blk32_ff);
	sfpw_host u_host (.clk, .cs_n, .sclk, .data_lane_in, .data_lane_out);

	always @(posedge clk) begin
		if (mem_wr_ff === 1'b1) begin
			img[mem_addr_ff[7:0]] = mem_data_ff;
			pg = mem_addr_ff[23:8];
			nwr++;
		end
		if (erase_req_ff === 1'b1) begin
			ea = erase_addr_ff;
			eb = erase_blk32_ff;
			ner++;
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic results();
		$display("mismatches %0d compared %0d", mismatches, n_compared);
		if (mismatches == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	function automatic logic [7:0] dat(input int i);
		return (i >= 256) ? 8'hee : 8'(i + 17);
	endfunction
	task automatic frame(input logic [7:0] op, input logic [23:0] a,
		input int na, input bit quad);
		@(posedge clk);
		u_host.start();
		u_host.put(op, 8, 0);
		for (int i = 0; i < na; i++)
			u_host.put(a[23 - 8 * i -: 8], 8, quad);
	endtask
	task automatic wrap(input logic [7:0] w);
		frame(OP_WRAP_SET, 24'h0, 3, 0);
		u_host.put(w, 8, 0);
		u_host.stop();
		#1;
	endtask
	task automatic write_enable_command();
		frame(OP_WRITE_ENABLE_COMMAND, 24'h0, 0, 0);
		u_host.stop();
	endtask
	task automatic prog(input logic [7:0] op, input logic [23:0] a,
		input int n, input int xb, input bit quad);
		write_enable_command();
		frame(op, a, 3, quad);
		nwr = 0;
		for (int i = 0; i < n; i++)
			u_host.put(dat(i), 8, quad);
		if (xb > 0)
			u_host.put(8'h0, xb, 0);
		u_host.stop();
		#1;
	endtask
	task automatic idle();
		for (int i = 0; i < 1000 && busy_flag !== 1'b0; i++)
			@(posedge clk);
		if (busy_flag !== 1'b0) begin
			mismatches++;
			results();
		end
		#1;
	endtask
	task automatic rd(input logic [23:0] a, input bit ld);
		@(posedge clk);
		rd_load <= ld;
		rd_step <= !ld;
		rd_start_addr <= a;
		@(posedge clk);
		rd_load <= 1'b0;
		rd_step <= 1'b0;
		#1 chk(rd_addr_ff, a);
	endtask

	initial begin
		logic [23:0] a;
		logic [23:0] m;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk) rd_quad_std <= 1'b1;
		#1 chk({wrap_disable_bit, wrap_length_bits, busy_flag}, 4'he);
		for (int k = 0; k < 4; k++) begin
			m = 24'((8 << k) - 1);
			wrap({1'b0, k[1:0], 5'h0});
			chk({wrap_disable_bit, wrap_length_bits}, {1'b0, k[1:0]});
			a = 24'h0001f3;
			rd(a, 1);
			for (int j = 0; j <= m + 1; j++) begin
				a = (a & ~m) | ((a + 24'h1) & m);
				rd(a, 0);
			end
		end
		wrap(8'h10);
		chk(wrap_disable_bit, 1'b1);
		rd(24'h0000ff, 1);
		rd(24'h000100, 0);
		@(posedge clk) rd_quad_std <= 1'b0;
		rd_wrap_cmd <= 1'b1;
		rd(24'h00013f, 1);
		rd(24'h000138, 0);
		@(posedge clk) four_lane_command_mode <= 1'b1;
		u_host.start();
		u_host.put(OP_SET_PARAM, 8, 1);
		u_host.put(8'h03, 8, 1);
		u_host.stop();
		#1 chk(wrap_length_bits, 2'h3);
		@(posedge clk) four_lane_command_mode <= 1'b0;
		frame(OP_PROG, 24'h000010, 3, 0);
		u_host.put(8'haa, 8, 0);
		u_host.stop();
		#1 chk(busy_flag, 1'b0);
		prog(OP_PROG, 24'h0123fe, 3, 0, 0);
		chk(busy_flag, 1'b1);
		frame(OP_STAT_LO, 24'h0, 0, 0);
		u_host.rdstat(s);
		chk(oe_n, 4'hd);
		u_host.stop();
		chk(s, 8'h03);
		chk(oe_n, 4'hf);
		idle();
		chk(nwr, 3);
		chk({img[8'hfe], img[8'hff], img[8'h00]}, 24'h111213);
		chk(pg, 16'h0123);
		chk(write_enable_latch, 1'b0);
		prog(OP_PROG, 24'h000200, 258, 0, 0);
		idle();
		chk(nwr, 256);
		chk({img[0], img[1], img[2], img[255]}, 32'heeee1310);
		prog(OP_PROG, 24'h000300, 1, 3, 0);
		chk(busy_flag, 1'b0);
		prog(OP_PROG_QUAD, 24'h000400, 2, 0, 1);
		chk(busy_flag, 1'b0);
		@(posedge clk) quad_enable_bit <= 1'b1;
		prog(OP_PROG_QUAD, 24'h000410, 2, 0, 1);
		idle();
		chk({nwr[7:0], img[8'h10], img[8'h11]}, 24'h021112);
		@(posedge clk) protect_active <= 1'b1;
		prog(OP_PROG, 24'h030080, 1, 0, 0);
		chk(busy_flag, 1'b0);
		for (int e = 0; e < 4; e++) begin
			write_enable_command();
			ner = 0;
			frame(eop[e], ead[e], 3, 0);
			if (e == 3)
				u_host.put(8'h0, 1, 0);
			u_host.stop();
			#1 chk(ner, e < 2);
			if (e == 0) begin
				chk({eb, ea}, 25'h0012000);
				wrap(8'h00);
				chk({wrap_disable_bit, wrap_length_bits}, 3'h7);
			end
			if (e == 1)
				chk({eb, ea}, 25'h1018000);
			idle();
		end
		results();
	end
endmodule // sfpw_core_test
`default_nettype wire
